//--- hw/energy_pkg.sv
package energy_pkg;

  // register byte addresses, one aligned word each
  localparam logic [7:0] ADDR_ENERGY_VALUE  = 8'h00; // active_energy_value, read only
  localparam logic [7:0] ADDR_ENERGY_RCLEAR = 8'h04; // active_energy_read_clear
  localparam logic [7:0] ADDR_DIVISOR       = 8'h08; // energy_divisor
  localparam logic [7:0] ADDR_OFFSET        = 8'h0c; // power_offset
  localparam logic [7:0] ADDR_NUMERATOR     = 8'h10; // pulse_ratio_numerator
  localparam logic [7:0] ADDR_DENOMINATOR   = 8'h14; // pulse_ratio_denominator
  localparam logic [7:0] ADDR_MODE          = 8'h18; // mode word
  localparam logic [7:0] ADDR_IRQ_ENABLE    = 8'h1c; // interrupt enable word
  localparam logic [7:0] ADDR_IRQ_STATUS    = 8'h20; // sticky flags, write one to clear
  localparam logic [7:0] ADDR_WAVEFORM      = 8'h24; // waveform sample, read only

  // mode word fields
  localparam int MODE_POS_ONLY_BIT = 15; // positive_only_accumulation
  localparam int MODE_WSRC_HI      = 14; // waveform source field
  localparam int MODE_WSRC_LO      = 13;
  localparam int MODE_WRATE_HI     = 12; // waveform rate select
  localparam int MODE_WRATE_LO     = 11;
  localparam logic [15:0] MODE_RESET = 16'h0000;

  // interrupt enable / status bit positions
  localparam int IRQ_HALF_BIT  = 0; // energy passed half of full scale
  localparam int IRQ_OVER_BIT  = 1; // energy overflow or underflow
  localparam int IRQ_WAVEFORM_SAMPLE_ENABLE_BIT  = 3; // waveform_sample_enable
  localparam logic [3:0] IEN_RESET = 4'h0;

  // widths and sizes
  localparam int ACC_W    = 49; // internal accumulator
  localparam int ENERGY_W = 24; // readable upper part
  localparam int SAMPLE_W = 24; // power sample and waveform sample
  localparam int SCALED_W = 34; // sample shifted by eight plus sign room
  localparam int OFS_SHIFT = 8; // offset 0x0100 is one sample lsb
  localparam int RATIO_W  = 12;
  localparam int PER_W    = 24; // calibration pulse period counter

  // timing: master clock and the quarter-rate accumulation tick
  localparam longint CLK_HZ        = 40_000_000;
  localparam int     TICK_DIV      = 4;
  localparam longint PULSE_LONG_MS = 180; // period above this gets a fixed width
  localparam longint PULSE_WIDE_MS = 90;  // that fixed width
  localparam longint LONG_TICKS_L  = (CLK_HZ / TICK_DIV) * PULSE_LONG_MS / 1000;
  localparam longint WIDE_TICKS_L  = (CLK_HZ / TICK_DIV) * PULSE_WIDE_MS / 1000;
  localparam int     LONG_TICKS    = int'(LONG_TICKS_L);
  localparam int     WIDE_TICKS    = int'(WIDE_TICKS_L);
  localparam logic [PER_W-1:0] MIN_WIDTH_TICKS = 24'h000010; // sixteen quarter-rate ticks
  localparam int     WAVE_BASE_DIV = 128; // master cycles per fastest waveform sample

  // apb carriers
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_s;

  // upstream power datapath output
  typedef struct packed {
    logic signed [SAMPLE_W-1:0] sample;
  } power_in_s;

  // whole block state
  typedef struct packed {
    logic signed [ACC_W-1:0]    acc;
    logic [1:0]                 quarter;
    logic [9:0]                 wave_cnt;
    logic [SAMPLE_W-1:0]        wave;
    logic [7:0]                 divisor;
    logic [15:0]                offset;
    logic [RATIO_W-1:0]         num;
    logic [RATIO_W-1:0]         den;
    logic [15:0]                mode;
    logic [3:0]                 ien;
    logic [1:0]                 stat;
    logic [RATIO_W:0]           frac;
    logic [PER_W-1:0]           period_cnt;
    logic [PER_W-1:0]           width_cnt;
    logic                       cf;
    logic                       ready;
    logic                       err;
    logic [31:0]                rdata;
  } state_s;

endpackage

//--- hw/active_energy_accumulator_pulse_out.sv
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/10ps
`default_nettype none

module active_energy_accumulator_pulse_out
  import energy_pkg::*;
#(
  parameter int LONG_PERIOD_TICKS = LONG_TICKS, // 180 ms in quarter-rate ticks
  parameter int WIDE_PULSE_TICKS  = WIDE_TICKS  // 90 ms in quarter-rate ticks
)(
  input  wire logic      pclk,
  input  wire logic      presetn,
  input  wire apb_req_s  apb_req,
  output var  apb_rsp_s  apb_rsp,
  input  wire power_in_s power_in,
  output logic           calibration_pulse_out,
  output logic           irq_n
);

  localparam logic [PER_W-1:0] LONG_P = PER_W'(LONG_PERIOD_TICKS); // width-matched threshold
  localparam logic [PER_W-1:0] WIDE_P = PER_W'(WIDE_PULSE_TICKS);  // width-matched fixed width

  state_s r_reg;   // registered state
  state_s r_next;  // its next value

  // combinational helpers
  logic                       tick;         // quarter-rate enable
  logic                       access;       // apb access phase
  logic                       do_write;     // write completes this edge
  logic                       do_read;      // read captured this edge
  logic                       mapped;       // address hits a register
  logic signed [SCALED_W-1:0] scaled;       // sample with offset, 1/256 lsb units
  logic signed [SCALED_W-1:0] quotient;     // after divisor
  logic signed [ACC_W-1:0]    addend;       // what goes into the accumulator
  logic signed [ACC_W-1:0]    acc_base;     // accumulator after any read-clear
  logic signed [ACC_W-1:0]    acc_sum;      // accumulator after the addition
  logic [ENERGY_W-1:0]        e_old;        // readable value before
  logic [ENERGY_W-1:0]        e_new;        // readable value after
  logic                       half_set;     // half-full event
  logic                       over_set;     // overflow or underflow event
  logic                       dfc_pulse;    // digital_to_freq_stage output
  logic [RATIO_W:0]           n_eff;        // numerator plus one, clamped
  logic [RATIO_W:0]           d_eff;        // denominator plus one
  logic [RATIO_W+1:0]         frac_sum;     // ratio accumulator step
  logic                       emit;         // calibration pulse starts
  logic [PER_W-1:0]           width_new;    // width chosen for a new pulse
  logic [9:0]                 wave_limit;   // waveform divider reload
  logic [1:0]                 clr;          // status bits software clears
  logic [31:0]                rd_mux;       // read data selection

  // divider, offset and events
  always_comb
  begin
    r_next   = r_reg;
    tick     = (r_reg.quarter == 2'h3);
    access   = apb_req.psel & apb_req.penable;
    do_write = access & r_reg.ready & apb_req.pwrite;
    do_read  = access & ~r_reg.ready & ~apb_req.pwrite;

    // quarter-rate enable counter, runs free
    r_next.quarter = r_reg.quarter + 2'h1;

    // offset in 1/256 of a sample lsb, added before division
    scaled = (SCALED_W'(power_in.sample) <<< OFS_SHIFT) + SCALED_W'(signed'(r_reg.offset));

    // zero divisor behaves as one
    if (r_reg.divisor == 8'h00)
    begin
      quotient = scaled;
    end
    else
    begin
      quotient = scaled / signed'({26'h0, r_reg.divisor});
    end

    // negative samples dropped in positive-only mode
    if (r_reg.mode[MODE_POS_ONLY_BIT] && quotient < 0)
    begin
      addend = '0;
    end
    else
    begin
      addend = ACC_W'(quotient);
    end

    // read-clear: clearing the upper part first keeps this tick's sample
    acc_base = r_reg.acc;
    if (do_read && apb_req.paddr == ADDR_ENERGY_RCLEAR)
    begin
      acc_base[ACC_W-1 -: ENERGY_W] = '0;
    end

    // signed addition wraps naturally at both ends
    acc_sum = tick ? acc_base + addend : acc_base;
    r_next.acc = acc_sum;

    e_old = acc_base[ACC_W-1 -: ENERGY_W];
    e_new = acc_sum[ACC_W-1 -: ENERGY_W];

    // half full: top two bits differ means magnitude past half scale
    half_set = tick & (e_new[23] ^ e_new[22]) & ~(e_old[23] ^ e_old[22]);
    // overflow: operands agree in sign, result does not
    over_set = tick & (acc_base[ACC_W-1] == addend[ACC_W-1])
             & (acc_sum[ACC_W-1] != acc_base[ACC_W-1]);

    // one internal pulse whenever the readable value steps
    dfc_pulse = tick & (e_new != e_old);

    // ratio registers: zero acts as one, then ratio clamped to one
    n_eff = (r_reg.num == '0) ? 13'h0002 : {1'b0, r_reg.num} + 13'h0001;
    d_eff = (r_reg.den == '0) ? 13'h0002 : {1'b0, r_reg.den} + 13'h0001;
    if (n_eff > d_eff)
    begin
      n_eff = d_eff;
    end

    // fractional pulse divider: d_eff/n_eff internal pulses per output pulse
    frac_sum = {1'b0, r_reg.frac} + {1'b0, n_eff};
    emit     = 1'b0;
    if (dfc_pulse)
    begin
      if (frac_sum >= {1'b0, d_eff})
      begin
        emit          = 1'b1;
        r_next.frac   = (RATIO_W+1)'(frac_sum - {1'b0, d_eff});
      end
      else
      begin
        r_next.frac   = frac_sum[RATIO_W:0];
      end
    end

    // width: fixed when period is long, else half period, never under 16 ticks
    if (r_reg.period_cnt > LONG_P)
    begin
      width_new = WIDE_P;
    end
    else if ((r_reg.period_cnt >> 1) < MIN_WIDTH_TICKS)
    begin
      width_new = MIN_WIDTH_TICKS;
    end
    else
    begin
      width_new = r_reg.period_cnt >> 1;
    end

    // pulse timing counts in quarter-rate ticks
    if (tick)
    begin
      if (emit)
      begin
        r_next.period_cnt = '0;
        r_next.width_cnt  = width_new;
      end
      else
      begin
        // saturate so a very slow load still reads as long
        if (r_reg.period_cnt != '1)
        begin
          r_next.period_cnt = r_reg.period_cnt + 24'h000001;
        end
        if (r_reg.width_cnt != '0)
        begin
          r_next.width_cnt = r_reg.width_cnt - 24'h000001;
        end
      end
    end
    r_next.cf = (r_next.width_cnt != '0);

    // waveform sampling at the selected rate
    wave_limit = 10'(WAVE_BASE_DIV - 1) << r_reg.mode[MODE_WRATE_HI:MODE_WRATE_LO];
    wave_limit = wave_limit | ((10'h001 << r_reg.mode[MODE_WRATE_HI:MODE_WRATE_LO]) - 10'h001);
    if (r_reg.wave_cnt >= wave_limit)
    begin
      r_next.wave_cnt = '0;
      if (r_reg.mode[MODE_WSRC_HI:MODE_WSRC_LO] == 2'b00 && r_reg.ien[IRQ_WAVEFORM_SAMPLE_ENABLE_BIT])
      begin
        // sample in waveform lsb units, offset included
        r_next.wave = scaled[OFS_SHIFT +: SAMPLE_W];
      end
    end
    else
    begin
      r_next.wave_cnt = r_reg.wave_cnt + 10'h001;
    end

    // address decode
    unique case (apb_req.paddr)
      ADDR_ENERGY_VALUE, ADDR_ENERGY_RCLEAR, ADDR_DIVISOR, ADDR_OFFSET,
      ADDR_NUMERATOR, ADDR_DENOMINATOR, ADDR_MODE, ADDR_IRQ_ENABLE,
      ADDR_IRQ_STATUS, ADDR_WAVEFORM: mapped = 1'b1;
      default:                        mapped = 1'b0;
    endcase

    // read data, narrow registers sit low with zeros above
    unique case (apb_req.paddr)
      ADDR_ENERGY_VALUE:  rd_mux = {8'h00, e_old};
      ADDR_ENERGY_RCLEAR: rd_mux = {8'h00, r_reg.acc[ACC_W-1 -: ENERGY_W]};
      ADDR_DIVISOR:       rd_mux = {24'h000000, r_reg.divisor};
      ADDR_OFFSET:        rd_mux = {16'h0000, r_reg.offset};
      ADDR_NUMERATOR:     rd_mux = {20'h00000, r_reg.num};
      ADDR_DENOMINATOR:   rd_mux = {20'h00000, r_reg.den};
      ADDR_MODE:          rd_mux = {16'h0000, r_reg.mode};
      ADDR_IRQ_ENABLE:    rd_mux = {28'h0000000, r_reg.ien};
      ADDR_IRQ_STATUS:    rd_mux = {30'h00000000, r_reg.stat};
      ADDR_WAVEFORM:      rd_mux = {8'h00, r_reg.wave};
      default:            rd_mux = 32'h00000000;
    endcase

    // one wait state so read data leaves a flip-flop
    r_next.ready = access & ~r_reg.ready;
    if (access && !r_reg.ready)
    begin
      r_next.rdata = apb_req.pwrite ? 32'h00000000 : rd_mux;
      r_next.err   = ~mapped;
    end
    else if (!access)
    begin
      r_next.err = 1'b0;
    end

    // register writes at the completing edge
    clr = 2'b00;
    if (do_write)
    begin
      unique case (apb_req.paddr)
        ADDR_DIVISOR:     r_next.divisor = apb_req.pwdata[7:0];
        ADDR_OFFSET:      r_next.offset  = apb_req.pwdata[15:0];
        ADDR_NUMERATOR:   r_next.num     = apb_req.pwdata[RATIO_W-1:0];
        ADDR_DENOMINATOR: r_next.den     = apb_req.pwdata[RATIO_W-1:0];
        ADDR_MODE:        r_next.mode    = apb_req.pwdata[15:0];
        ADDR_IRQ_ENABLE:  r_next.ien     = apb_req.pwdata[3:0];
        ADDR_IRQ_STATUS:  clr            = apb_req.pwdata[1:0];
        default:          clr            = 2'b00; // read-only or unmapped: ignored
      endcase
    end

    // sticky flags, a new event beats a clear in the same cycle
    r_next.stat[IRQ_HALF_BIT] = (r_reg.stat[IRQ_HALF_BIT] & ~clr[IRQ_HALF_BIT]) | half_set;
    r_next.stat[IRQ_OVER_BIT] = (r_reg.stat[IRQ_OVER_BIT] & ~clr[IRQ_OVER_BIT]) | over_set;
  end

  // single clocked process for all state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r_reg      <= '0;
      r_reg.mode <= MODE_RESET;
      r_reg.ien  <= IEN_RESET;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // outputs
  always_comb
  begin
    apb_rsp.pready        = r_reg.ready;
    apb_rsp.pslverr       = r_reg.ready & r_reg.err;
    apb_rsp.prdata        = r_reg.rdata;
    calibration_pulse_out = r_reg.cf;
    irq_n                 = ~|(r_reg.stat & r_reg.ien[1:0]);
  end

endmodule

`default_nettype wire

//--- tb/cal_counter.sv
`timescale 1ns/10ps
`default_nettype none
// far-side meter: counts calibration pulses and times the last one
module cal_counter (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pulse,
  output var  int   n_pulses,
  output var  int   last_high
);
  int   run;  // cycles high so far
  logic prev; // level at the last edge
  // counts rising edges only, so a long pulse is still one pulse
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      n_pulses <= 0;
      last_high <= 0;
      run <= 0;
      prev <= 1'b0;
    end
    else
    begin
      prev <= pulse;
      run <= pulse ? run + 1 : 0;
      if (pulse && !prev)
        n_pulses <= n_pulses + 1;
      if (!pulse && prev)
        last_high <= run;
    end
endmodule
`default_nettype wire

//--- tb/active_energy_accumulator_pulse_out_chk.sv
`timescale 1ns/10ps
`default_nettype none
// watches bus timing, read data shape and pulse widths at the ports
module pulse_out_chk
  import energy_pkg::*;
#(
  parameter int LONG_PERIOD_TICKS = 200, // long-period limit in ticks
  parameter int WIDE_PULSE_TICKS  = 100  // fixed wide pulse in ticks
)(
  input wire logic      pclk,
  input wire logic      presetn,
  input wire apb_req_s  apb_req,
  input wire apb_rsp_s  apb_rsp,
  input wire power_in_s power_in,
  input wire logic      calibration_pulse_out,
  input wire logic      irq_n
);
  // widest legal pulse in clocks, one tick of slack for the phase
  localparam int MAXW = 4 * ((WIDE_PULSE_TICKS > LONG_PERIOD_TICKS / 2) ? WIDE_PULSE_TICKS : LONG_PERIOD_TICKS / 2) + 4;
  int   hi;     // clocks the pulse output has been high
  logic acc_ph; // access phase of a transfer
  assign acc_ph = apb_req.psel && apb_req.penable;
  // pulse length counter, registered so reset leaves it clean
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      hi <= 0;
    else
      hi <= calibration_pulse_out ? hi + 1 : 0;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_one_wait: assert property (acc_ph && !apb_rsp.pready |=> apb_rsp.pready) else $error("late answer");
  chk_ready_once: assert property (apb_rsp.pready |=> !apb_rsp.pready) else $error("ready too long");
  chk_ready_cause: assert property (apb_rsp.pready |-> acc_ph && $past(acc_ph)) else $error("stray ready");
  chk_err_unmapped: assert property (apb_rsp.pready && apb_req.paddr > 8'h24 |-> apb_rsp.pslverr && apb_rsp.prdata == 0)
    else $error("unmapped not refused");
  chk_err_mapped: assert property (apb_rsp.pready && apb_req.paddr <= 8'h24 && apb_req.paddr[1:0] == 2'b00
    |-> !apb_rsp.pslverr) else $error("mapped refused");
  chk_rdata_width: assert property (apb_rsp.pready |-> apb_rsp.prdata[31:24] == 8'h00) else $error("wide data");
  chk_write_rdata: assert property (apb_rsp.pready && apb_req.pwrite |-> apb_rsp.prdata == 0) else $error("write data");
  chk_pulse_min: assert property ($fell(calibration_pulse_out) |-> hi >= 61) else $error("pulse too short");
  chk_pulse_max: assert property (calibration_pulse_out |-> hi <= MAXW) else $error("pulse too long");
  cover property ($rose(calibration_pulse_out));
  cover property (apb_rsp.pready && apb_rsp.pslverr);
  cover property (apb_rsp.pready && !apb_req.pwrite);
endmodule
bind active_energy_accumulator_pulse_out pulse_out_chk #(
  .LONG_PERIOD_TICKS(LONG_PERIOD_TICKS),
  .WIDE_PULSE_TICKS (WIDE_PULSE_TICKS)
) chk (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .power_in(power_in),
  .calibration_pulse_out(calibration_pulse_out), .irq_n(irq_n));
`default_nettype wire

//--- tb/active_energy_accumulator_pulse_out_bench.sv
`timescale 1ns/10ps
`default_nettype none
// drives bus and power stream, mirrors the block in a behavioural model
module active_energy_accumulator_pulse_out_bench
  import energy_pkg::*;
;
  localparam int WP = 100; // shortened wide pulse, ticks
  localparam int LP = 200; // shortened long-period limit, ticks
  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  apb_req_s           req = '0;
  apb_rsp_s           rsp;
  power_in_s          pin = '0;
  logic               cf;
  logic               irq_n;
  int                 miscompares = 0;
  int                 n_compared = 0;
  int                 cycles = 0;
  int                 seed = 40;
  int                 n_seen;   // meter pulse count
  int                 w_seen;   // meter last width
  logic signed [48:0] macc;     // model accumulator
  logic [1:0]         q;        // model quarter count
  int                 frac;     // model pulse fraction
  int                 m_pulses; // model rising edges of the output
  int                 m_per;    // model ticks since the last output pulse start
  int                 m_wid;    // model ticks left of the current pulse
  logic               m_lvl;    // model output level
  logic               m_emit;   // model pulse start this tick
  int                 n;
  int                 d;
  longint             s;
  logic [23:0]        old;
  logic [7:0]         m_div = '0;
  logic [15:0]        m_ofs = '0;
  logic [15:0]        m_mode = '0;
  logic [11:0]        m_num = '0;
  logic [11:0]        m_den = '0;
  logic [3:0]         m_ien = '0;
  logic [7:0]         ra [6] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};

  active_energy_accumulator_pulse_out #(.LONG_PERIOD_TICKS(LP), .WIDE_PULSE_TICKS(WP)) dut (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .power_in(pin),
    .calibration_pulse_out(cf), .irq_n(irq_n));
  cal_counter meter (.pclk(pclk), .presetn(presetn), .pulse(cf), .n_pulses(n_seen), .last_high(w_seen));

  always #12.5 pclk = ~pclk;

  // hang guard: a run this long means a stuck handshake
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      complete_run();
    end
  end

  // model: one tick every fourth clock, then the pulse divider
  always @(posedge pclk)
    if (!presetn)
    begin
      q = 2'd0;
      macc = '0;
      frac = 0;
      m_pulses = 0;
      m_per = 0;
      m_wid = 0;
      m_lvl = 1'b0;
    end
    else
    begin
      if (req.psel && req.penable && !rsp.pready && !req.pwrite && req.paddr == ADDR_ENERGY_RCLEAR)
        macc[48:25] = '0;
      if (q == 2'd3)
      begin
        s = ((longint'($signed(pin.sample)) <<< 8) + longint'($signed(m_ofs))) / longint'((m_div == 0) ? 8'd1 : m_div);
        old = macc[48:25];
        m_emit = 1'b0;
        if (!(m_mode[15] && s < 0))
          macc = macc + 49'(s);
        if (macc[48:25] != old)
        begin
          n = (m_num == 0) ? 2 : m_num + 1;
          d = (m_den == 0) ? 2 : m_den + 1;
          frac += (n > d) ? d : n;
          if (frac >= d)
          begin
            frac -= d;
            m_emit = 1'b1;
          end
        end
        // a long first pulse can swallow the next start, so count edges, not starts
        if (m_emit)
        begin
          m_wid = (m_per > LP) ? WP : ((m_per / 2 < 16) ? 16 : m_per / 2);
          m_per = 0;
        end
        else
        begin
          if (m_per < 24'hffffff)
            m_per++;
          if (m_wid > 0)
            m_wid--;
        end
        if (m_wid > 0 && !m_lvl)
          m_pulses++;
        m_lvl = (m_wid > 0);
      end
      q++;
    end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one transfer; model registers follow at the edge the write lands
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [31:0] exp, input logic e);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
    @(posedge pclk);
    req.penable <= 1'b1;
    @(posedge pclk);
    while (rsp.pready !== 1'b1)
      @(posedge pclk);
    check(rsp.prdata, exp);
    check({31'h0, rsp.pslverr}, {31'h0, e});
    if (w)
      case (a)
        ADDR_DIVISOR:     m_div <= wd[7:0];
        ADDR_OFFSET:      m_ofs <= wd[15:0];
        ADDR_NUMERATOR:   m_num <= wd[11:0];
        ADDR_DENOMINATOR: m_den <= wd[11:0];
        ADDR_MODE:        m_mode <= wd[15:0];
        ADDR_IRQ_ENABLE:  m_ien <= wd[3:0];
        default:          ;
      endcase
    req <= '0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bus(1'b1, a, v, 32'h0, 1'b0);
  endtask

  // what the model says a register reads back as
  function automatic logic [31:0] regval(input logic [7:0] a);
    case (a)
      ADDR_ENERGY_VALUE: return {8'h00, macc[48:25]};
      ADDR_DIVISOR:      return {24'h0, m_div};
      ADDR_OFFSET:       return {16'h0, m_ofs};
      ADDR_NUMERATOR:    return {20'h0, m_num};
      ADDR_DENOMINATOR:  return {20'h0, m_den};
      ADDR_MODE:         return {16'h0, m_mode};
      ADDR_IRQ_ENABLE:   return {28'h0, m_ien};
      default:           return 32'h0;
    endcase
  endfunction

  // one ratio at a slow steady power, then let the last pulse end
  task automatic pulses(input logic [11:0] nm, input logic [11:0] dn, input int k);
    wr(ADDR_NUMERATOR, {20'h0, nm});
    wr(ADDR_DENOMINATOR, {20'h0, dn});
    pin.sample <= 24'h001000;
    repeat (k) @(posedge pclk);
    pin.sample <= 24'h0;
    repeat (500) @(posedge pclk);
    check(n_seen, m_pulses);
  endtask

  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    logic [31:0] v;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a <= 'h24; a += 4)
      bus(1'b0, 8'(a), 32'h0, 32'h0, 1'b0);
    bus(1'b0, 8'h28, 32'h0, 32'h0, 1'b1);
    wr(ADDR_ENERGY_VALUE, 32'hffff_ffff);
    pin.sample <= 24'h000050;
    repeat (300) @(posedge pclk);
    bus(1'b0, ADDR_WAVEFORM, 32'h0, 32'h0, 1'b0);
    pin.sample <= 24'h0;
    for (int i = 0; i < 6; i++)
    begin
      wr(ra[i], $random(seed));
      bus(1'b0, ra[i], 32'h0, regval(ra[i]), 1'b0);
    end
    wr(ADDR_OFFSET, 32'h0);
    wr(ADDR_DIVISOR, 32'h0);
    wr(ADDR_MODE, 32'h0);
    pulses(12'h007, 12'h001, 600);
    pulses(12'h000, 12'h007, 2100);
    pulses(12'h000, 12'h00f, 3200);
    check({31'h0, (w_seen >= 4 * WP - 4) && (w_seen <= 4 * WP + 4)}, 32'h1);
    wr(ADDR_IRQ_ENABLE, 32'h8);
    for (int r = 0; r < 4; r++)
    begin
      wr(ADDR_MODE, 32'(r) << 11);
      pin.sample <= 24'(r + 3);
      repeat ((128 << r) + 8) @(posedge pclk);
      bus(1'b0, ADDR_WAVEFORM, 32'h0, 32'(r + 3), 1'b0);
    end
    wr(ADDR_DENOMINATOR, 32'hfff);
    for (int i = 0; i < 8; i++)
    begin
      v = $random(seed);
      wr(ADDR_DIVISOR, {24'h0, v[7:0]});
      wr(ADDR_OFFSET, {16'h0, v[15:8], 8'h00});
      wr(ADDR_MODE, {16'h0, v[16], 15'h0});
      pin.sample <= 24'($random(seed));
      repeat (40) @(posedge pclk);
      pin.sample <= -{{16{v[15]}}, v[15:8]};
      repeat (8) @(posedge pclk);
      bus(1'b0, ADDR_ENERGY_VALUE, 32'h0, regval(ADDR_ENERGY_VALUE), 1'b0);
      bus(1'b0, ADDR_ENERGY_RCLEAR, 32'h0, regval(ADDR_ENERGY_VALUE), 1'b0);
      bus(1'b0, ADDR_ENERGY_VALUE, 32'h0, 32'h0, 1'b0);
    end
    check(n_seen, m_pulses);
    check({31'h0, irq_n}, 32'h1);
    complete_run();
  end
endmodule
`default_nettype wire
